// >>> hw/dma_target_cfg.svh
/*
 * Constants of the timer-linked DMA start-target selector: register
 * indices, field positions, reset value and the target base addresses.
 * Assumes a 32-bit APB slave with 12-bit byte addresses.
 */
// Operation
// - channels 2 and 3 each own an 8-bit target selector register
// - selector only matters for transfers whose destination is the timer unit
// - selector readable and writable per byte and per single bit
// - bits 7 to 4 read zero; writes to them change nothing
// - code k (0 to 11) selects halfword address base plus 2k
// - codes map in order: option, deadtime1, deadtime0, compares 5A..1A
// - codes 6 and 7: compare 2B/1B in triangle mode, else pattern 1/0
// - timer compare or overflow triggers; completion interrupts stay separate
`ifndef DMA_TARGET_CFG_SVH
`define DMA_TARGET_CFG_SVH

// register indices; byte address is four times the index
`define SEL_CH2_IDX 10'h024
`define SEL_CH3_IDX 10'h026
`define BITOP_IDX 10'h028
`define SEL_CH2_ADDR {`SEL_CH2_IDX, 2'b00}
`define SEL_CH3_ADDR {`SEL_CH3_IDX, 2'b00}
`define BITOP_ADDR {`BITOP_IDX, 2'b00}

// selector layout and reset value
`define SEL_RESET 8'h00
`define SEL_CODE_MSB 3
`define TARGET_CODE_LAST 4'hB

// single-bit access register fields
`define BITOP_POS_MSB 2
`define BITOP_VAL_BIT 8
`define BITOP_WR_BIT 9
`define BITOP_CH_BIT 12

// halfword target base per channel
`define CH2_TARGET_BASE 32'hFFFF_FB40
`define CH3_TARGET_BASE 32'hFFFF_FBC0

`endif

// >>> hw/dma_target_pkg.sv
/*
 * Types shared by the selector channel, trigger stage and top.
 * Assumes the constants header is included alongside.
 */
package dma_target_pkg;

   // identity of the timer register a transfer starts at
   typedef enum logic [3:0] {
      TGT_OPTION_RELOAD = 4'h0,
      TGT_DEADTIME1 = 4'h1,
      TGT_DEADTIME0 = 4'h2,
      TGT_COMPARE5A = 4'h3,
      TGT_COMPARE4A = 4'h4,
      TGT_COMPARE3B = 4'h5,
      TGT_COMPARE2B = 4'h6,
      TGT_COMPARE1B = 4'h7,
      TGT_COMPARE0A = 4'h8,
      TGT_COMPARE3A = 4'h9,
      TGT_COMPARE2A = 4'hA,
      TGT_COMPARE1A = 4'hB,
      TGT_PATTERN1 = 4'hC,
      TGT_PATTERN0 = 4'hD,
      TGT_NONE = 4'hF
   } target_id_t;

   // start target handed to the transfer engine
   typedef struct packed {
      logic valid;
      target_id_t id;
      logic [31:0] addr;
   } target_sel_t;

   // what the timer unit reports per channel
   typedef struct packed {
      logic tpwm_mode;
      logic compare_match_irq;
      logic overflow_irq;
   } timer_status_t;

   typedef struct packed {
      logic [3:0] code;
      target_sel_t sel;
   } chan_state_t;

   typedef struct packed {
      logic trigger;
      logic done_irq;
   } trig_state_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pslverr;
      logic [2:0] bit_ptr;
      logic bit_ch;
   } bus_state_t;

endpackage : dma_target_pkg

// >>> hw/target_select_channel.sv
/*
 * One channel's selector register and its decode into a start target.
 * Assumes write strobes come already decoded from the bus slave.
 */
`include "dma_target_cfg.svh"

module target_select_channel
   import dma_target_pkg::*;
#(
   parameter logic [31:0] BASE = `CH2_TARGET_BASE
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic bit_wr,
   input wire logic [2:0] bit_pos,
   input wire logic bit_val,
   input wire logic dst_is_timer,
   input wire logic tpwm_mode,
   output logic [7:0] sel_value,
   output target_sel_t sel
);

   localparam logic [7:0] SEL_RST = `SEL_RESET;

   chan_state_t state_reg;
   chan_state_t state_next;

   // code to register identity; codes 6 and 7 follow the timer mode
   function automatic target_id_t decode_id(input logic [3:0] code, input logic tpwm);
      case (code)
         4'h0: decode_id = TGT_OPTION_RELOAD;
         4'h1: decode_id = TGT_DEADTIME1;
         4'h2: decode_id = TGT_DEADTIME0;
         4'h3: decode_id = TGT_COMPARE5A;
         4'h4: decode_id = TGT_COMPARE4A;
         4'h5: decode_id = TGT_COMPARE3B;
         4'h6: decode_id = tpwm ? TGT_COMPARE2B : TGT_PATTERN1;
         4'h7: decode_id = tpwm ? TGT_COMPARE1B : TGT_PATTERN0;
         4'h8: decode_id = TGT_COMPARE0A;
         4'h9: decode_id = TGT_COMPARE3A;
         4'hA: decode_id = TGT_COMPARE2A;
         4'hB: decode_id = TGT_COMPARE1A;
         default: decode_id = TGT_NONE;
      endcase
   endfunction : decode_id

   // byte or single-bit update; upper nibble has no storage at all
   always_comb begin
      state_next = state_reg;
      if (wr_en) begin
         state_next.code = wr_data[`SEL_CODE_MSB:0];
      end else if (bit_wr && !bit_pos[2]) begin
         state_next.code[bit_pos[1:0]] = bit_val;
      end
      // target follows the live code, so a mid-transfer rewrite would steer it
      state_next.sel.addr = BASE + {27'h0, state_reg.code, 1'b0};
      state_next.sel.valid = dst_is_timer &&
         (state_reg.code <= `TARGET_CODE_LAST);
      state_next.sel.id = decode_id(state_reg.code, tpwm_mode);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg.code <= SEL_RST[3:0];
         state_reg.sel.valid <= 1'b0;
         state_reg.sel.id <= TGT_NONE;
         state_reg.sel.addr <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sel_value = {4'h0, state_reg.code};
   assign sel = state_reg.sel;

endmodule : target_select_channel

// >>> hw/dma_timer_trigger.sv
/*
 * Trigger and completion stage of one timer-linked channel.
 * Assumes timer and transfer engine run on ref_clk.
 */
`include "dma_target_cfg.svh"

module dma_timer_trigger
   import dma_target_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic chan_enable,
   input wire timer_status_t status,
   input wire logic xfer_done,
   output logic trigger,
   output logic done_irq
);

   trig_state_t state_reg;
   trig_state_t state_next;

   // compare match or overflow starts a transfer; completion has its own line
   always_comb begin
      state_next.trigger = chan_enable &&
         (status.compare_match_irq || status.overflow_irq);
      state_next.done_irq = xfer_done;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign trigger = state_reg.trigger;
   assign done_irq = state_reg.done_irq;

endmodule : dma_timer_trigger

// >>> hw/dma_timer_target_select.sv
/*
 * Start-target selector for the two timer-linked DMA channels, with its
 * APB slave. Index 0 is channel 2, index 1 is channel 3.
 * Assumes an APB master on ref_clk and timer/engine logic on ref_clk.
 */
// Local design decision: the APB interface to the registers.
`include "dma_target_cfg.svh"

module dma_timer_target_select
   import dma_target_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [1:0] dst_is_timer,
   input wire logic [1:0] chan_enable,
   input wire timer_status_t [1:0] timer_status,
   input wire logic [1:0] xfer_done,
   output target_sel_t [1:0] start_target,
   output logic [1:0] dma_trigger,
   output logic [1:0] done_irq
);

   localparam logic [11:0] CH2_ADDR = `SEL_CH2_ADDR;
   localparam logic [11:0] CH3_ADDR = `SEL_CH3_ADDR;
   localparam logic [11:0] BIT_ADDR = `BITOP_ADDR;
   localparam logic [31:0] CH2_BASE = `CH2_TARGET_BASE;
   localparam logic [31:0] CH3_BASE = `CH3_TARGET_BASE;

   bus_state_t bus_reg;
   bus_state_t bus_next;

   logic setup;
   logic access;
   logic [1:0] hit_sel;
   logic hit_bit;
   logic wr_ok;
   logic bitop_wr;
   logic [1:0] sel_wr;
   logic [1:0] bit_wr;
   logic [1:0][7:0] sel_value;
   logic [31:0] bit_read;

   // apb phase and address decode
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_sel[0] = (paddr == CH2_ADDR);
   assign hit_sel[1] = (paddr == CH3_ADDR);
   assign hit_bit = (paddr == BIT_ADDR);

   // writes land at the access edge; a refused address writes nothing
   assign wr_ok = access && pwrite && !bus_reg.pslverr && pstrb[0];
   assign sel_wr = {2{wr_ok}} & hit_sel;
   assign bitop_wr = wr_ok && pstrb[1] && hit_bit;

   // single-bit write aimed at one channel
   assign bit_wr[0] = bitop_wr && pwdata[`BITOP_WR_BIT] && !pwdata[`BITOP_CH_BIT];
   assign bit_wr[1] = bitop_wr && pwdata[`BITOP_WR_BIT] && pwdata[`BITOP_CH_BIT];

   // single-bit read returns the pointed bit with the pointer
   always_comb begin
      bit_read = 32'h0000_0000;
      bit_read[`BITOP_POS_MSB:0] = bus_reg.bit_ptr;
      bit_read[`BITOP_CH_BIT] = bus_reg.bit_ch;
      bit_read[`BITOP_VAL_BIT] = sel_value[bus_reg.bit_ch][bus_reg.bit_ptr];
   end

   // read data and error are captured in setup and stand through access
   always_comb begin
      bus_next = bus_reg;
      if (setup) begin
         bus_next.pslverr = !(hit_sel[0] || hit_sel[1] || hit_bit);
         bus_next.prdata = 32'h0000_0000;
         if (hit_sel[0]) begin
            bus_next.prdata = {24'h00_0000, sel_value[0]};
         end
         if (hit_sel[1]) begin
            bus_next.prdata = {24'h00_0000, sel_value[1]};
         end
         if (hit_bit) begin
            bus_next.prdata = bit_read;
         end
      end
      if (bitop_wr) begin
         bus_next.bit_ptr = pwdata[`BITOP_POS_MSB:0];
         bus_next.bit_ch = pwdata[`BITOP_CH_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bus_reg <= '0;
      end else begin
         bus_reg <= bus_next;
      end
   end

   // zero-wait slave
   assign pready = 1'b1;
   assign prdata = bus_reg.prdata;
   assign pslverr = bus_reg.pslverr && access;

   // one selector and one trigger stage per channel
   generate
      for (genvar i = 0; i < 2; i++) begin : g_chan
         target_select_channel #(
            .BASE((i == 0) ? CH2_BASE : CH3_BASE)
         ) u_sel (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .wr_en(sel_wr[i]),
            .wr_data(pwdata[7:0]),
            .bit_wr(bit_wr[i]),
            .bit_pos(pwdata[`BITOP_POS_MSB:0]),
            .bit_val(pwdata[`BITOP_VAL_BIT]),
            .dst_is_timer(dst_is_timer[i]),
            .tpwm_mode(timer_status[i].tpwm_mode),
            .sel_value(sel_value[i]),
            .sel(start_target[i])
         );
         dma_timer_trigger u_trig (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .chan_enable(chan_enable[i]),
            .status(timer_status[i]),
            .xfer_done(xfer_done[i]),
            .trigger(dma_trigger[i]),
            .done_irq(done_irq[i])
         );
      end
   endgenerate

   // checks on the outputs this block drives
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   logic [3:0] code_ch2;
   logic [3:0] code_ch3;
   assign code_ch2 = sel_value[0][3:0];
   assign code_ch3 = sel_value[1][3:0];

   // selector stays eight bits with a dead upper nibble
   AST_SEL_WIDTH: assert property (
      sel_value[0][7:4] == 4'h0 && sel_value[1][7:4] == 4'h0)
      else $error("selector upper nibble not zero");

   // any read of a selector shows zero above bit 3
   AST_READ_UPPER_ZERO: assert property (
      access && !pwrite && (hit_sel[0] || hit_sel[1]) |-> prdata[31:4] == 28'h000_0000)
      else $error("selector read shows upper bits");

   // byte write lands its low nibble one edge later
   AST_BYTE_WRITE: assert property (
      access && pwrite && pstrb[0] && hit_sel[0] && !pslverr
      |=> code_ch2 == $past(pwdata[3:0]))
      else $error("byte write to channel 2 not stored");

   // bit write on channel 3 stores its value at the addressed bit
   AST_BIT_WRITE: assert property (
      bit_wr[1] && !pwdata[2]
      |=> code_ch3[$past(pwdata[1:0])] == $past(pwdata[`BITOP_VAL_BIT]))
      else $error("bit write to channel 3 not stored");

   // bit write at an upper position leaves the code alone
   AST_UPPER_BIT_IGNORED: assert property (
      bit_wr[0] && pwdata[2] |=> $stable(code_ch2))
      else $error("upper bit write changed code");

   // address is base plus twice the code
   AST_ADDR_MAP: assert property (
      start_target[1].valid |-> start_target[1].addr == CH3_BASE + {27'h0, $past(code_ch3), 1'b0})
      else $error("channel 3 start address wrong");

   // not a timer-destined transfer means no target
   AST_OTHER_PATH: assert property (
      !dst_is_timer[0] |=> !start_target[0].valid)
      else $error("target valid for non-timer transfer");

   // code order for the fixed entries
   AST_CODE_ORDER: assert property (
      code_ch2 == 4'h1 && dst_is_timer[0] ##1 code_ch2 == 4'h1
      |-> start_target[0].id == TGT_DEADTIME1 && start_target[0].addr == 32'hFFFF_FB42)
      else $error("code 1 not deadtime 1");

   // code 6 swaps with the timer mode
   AST_MODE_SWAP: assert property (
      code_ch2 == 4'h6 && dst_is_timer[0]
      |=> start_target[0].id == ($past(timer_status[0].tpwm_mode) ? TGT_COMPARE2B : TGT_PATTERN1))
      else $error("code 6 target ignores timer mode");

   // prohibited codes never produce a target
   AST_PROHIBITED: assert property (
      code_ch3 > `TARGET_CODE_LAST |=> !start_target[1].valid)
      else $error("prohibited code gave a target");

   // trigger from compare or overflow, one edge later
   AST_TRIGGER: assert property (
      chan_enable[0] && (timer_status[0].compare_match_irq || timer_status[0].overflow_irq)
      |=> dma_trigger[0])
      else $error("timer event did not trigger channel 2");

   // completion line follows completion only, never a trigger
   AST_DONE_SEPARATE: assert property (
      !xfer_done[1] |=> !done_irq[1])
      else $error("completion interrupt raised without completion");

   // both selectors leave reset at the reset value
   AST_RESET_VALUE: assert property (
      $rose(resetn) |-> sel_value[0] == `SEL_RESET && sel_value[1] == `SEL_RESET)
      else $error("selector not cleared by reset");

   // byte write to channel 3 lands its low nibble one edge later
   AST_BYTE_WRITE_CH3: assert property (
      access && pwrite && pstrb[0] && hit_sel[1] && !pslverr
      |=> code_ch3 == $past(pwdata[3:0]))
      else $error("byte write to channel 3 not stored");

   // bit write on channel 2 stores its value at the addressed bit
   AST_BIT_WRITE_CH2: assert property (
      bit_wr[0] && !pwdata[2]
      |=> code_ch2[$past(pwdata[1:0])] == $past(pwdata[`BITOP_VAL_BIT]))
      else $error("bit write to channel 2 not stored");

   // upper bit positions on channel 3 have no storage
   AST_UPPER_BIT_CH3: assert property (
      bit_wr[1] && pwdata[2] |=> $stable(code_ch3))
      else $error("upper bit write changed channel 3 code");

   // channel 2 address is its base plus twice the code
   AST_ADDR_MAP_CH2: assert property (
      start_target[0].valid |-> start_target[0].addr == CH2_BASE + {27'h0, $past(code_ch2), 1'b0})
      else $error("channel 2 start address wrong");

   // channel 3 ignores its selector for non-timer transfers
   AST_OTHER_PATH_CH3: assert property (
      !dst_is_timer[1] |=> !start_target[1].valid)
      else $error("channel 3 target valid for non-timer transfer");

   // a timer transfer with a legal code always gets a target; reset edge excluded
   AST_TIMER_PATH: assert property (
      resetn && dst_is_timer[0] && code_ch2 <= `TARGET_CODE_LAST
      |=> start_target[0].valid)
      else $error("timer transfer got no target");

   // code 7 follows the timer mode as well
   AST_MODE_SWAP_CH3: assert property (
      code_ch3 == 4'h7
      |=> start_target[1].id == ($past(timer_status[1].tpwm_mode) ? TGT_COMPARE1B : TGT_PATTERN0))
      else $error("code 7 target ignores timer mode");

   // fixed codes map straight onto their register identity
   AST_CODE_ORDER_CH3: assert property (
      resetn && (code_ch3 < 4'h6 || (code_ch3 > 4'h7 && code_ch3 <= `TARGET_CODE_LAST))
      |=> start_target[1].id == $past(code_ch3))
      else $error("fixed code maps to wrong register");

   // trigger on channel 3 from compare or overflow, one edge later
   AST_TRIGGER_CH3: assert property (
      chan_enable[1] && (timer_status[1].compare_match_irq || timer_status[1].overflow_irq)
      |=> dma_trigger[1])
      else $error("timer event did not trigger channel 3");

   // a disabled channel never triggers
   AST_NO_TRIGGER_OFF: assert property (
      !chan_enable[1] |=> !dma_trigger[1])
      else $error("disabled channel triggered");

   // completion reaches its own line one edge later
   AST_DONE_FOLLOWS: assert property (
      xfer_done[0] |=> done_irq[0])
      else $error("completion interrupt missing");

   // a refused write changes neither selector
   AST_REFUSED_WRITE: assert property (
      access && pwrite && pslverr
      |=> $stable(code_ch2) && $stable(code_ch3))
      else $error("refused write changed a selector");

   // a write without the low byte lane changes nothing
   AST_LOW_LANE: assert property (
      access && pwrite && !pstrb[0] |=> $stable(sel_value))
      else $error("write without low lane changed a selector");

   // every access is answered at once
   AST_ZERO_WAIT: assert property (
      access |-> pready)
      else $error("access not answered");

   // error is shown in the access phase only
   AST_ERR_IN_ACCESS: assert property (
      !access |-> !pslverr)
      else $error("error shown outside access");

   // main scenarios
   COV_WRITE_CH3: cover property (access && pwrite && hit_sel[1]);
   COV_BIT_READ: cover property (access && !pwrite && hit_bit);
   COV_BIT_WRITE: cover property (bit_wr[0] ##1 bit_wr[1]);
   COV_TPWM_SWAP: cover property (start_target[0].id == TGT_COMPARE1B);
   COV_TRIGGER_BOTH: cover property (dma_trigger == 2'b11);

endmodule : dma_timer_target_select

// >>> bench/timer_engine_model.sv
/* timer unit and transfer engine stand-in for the two timer-linked channels.
   assumes ref_clk and a synchronous active-low reset shared with the design. */
module timer_engine_model
   import dma_target_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [1:0] tpwm,
   input wire logic [1:0] run,
   input wire logic slow,
   input wire logic [1:0] dma_trigger,
   output timer_status_t [1:0] timer_status,
   output logic [1:0] xfer_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt [2];
   logic [2:0] busy [2];

   // counters raise compare and overflow; the engine finishes 1 or 4 cycles after a trigger
   always @(posedge ref_clk) begin
      for (int i = 0; i < 2; i++) begin
         if (!resetn) begin
            cnt[i] <= 4'h0;
            busy[i] <= 3'h0;
            timer_status[i] <= '0;
            xfer_done[i] <= 1'b0;
         end else begin
            cnt[i] <= cnt[i] + (run[i] ? 4'(i + 1) : 4'h0);
            timer_status[i] <= {tpwm[i], run[i] && cnt[i] == 4'h6, run[i] && cnt[i] == 4'h0};
            xfer_done[i] <= busy[i] == 3'h1;
            if (dma_trigger[i])
               busy[i] <= slow ? 3'h4 : 3'h1;
            else if (busy[i] != 3'h0)
               busy[i] <= busy[i] - 3'h1;
         end
      end
   end
endmodule : timer_engine_model

// >>> bench/testbench.sv
/* self-checking bench of the timer-linked DMA start-target selector.
   assumes the package, the design and the timer and engine model are compiled first. */
`include "dma_target_cfg.svh"

module testbench
   import dma_target_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] ch2_a = `SEL_CH2_ADDR;
   localparam logic [11:0] ch3_a = `SEL_CH3_ADDR;
   localparam logic [11:0] bit_a = `BITOP_ADDR;
   logic ref_clk = 1'b0;
   logic resetn, psel, penable, pwrite, pready, pslverr, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [1:0] dst_is_timer, chan_enable, xfer_done, dma_trigger, done_irq, tpwm, run;
   logic [1:0] trig_exp, done_exp;
   timer_status_t [1:0] timer_status;
   target_sel_t [1:0] start_target;
   logic [33:0] expq [$];
   logic [33:0] note;
   int errors = 0;
   int cmp_count = 0;
   int seed = 31;
   int cycles = 0;

   always #2.5 ref_clk = ~ref_clk;

   dma_timer_target_select dut_u (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .prdata, .pslverr, .dst_is_timer, .chan_enable,
      .timer_status, .xfer_done, .start_target, .dma_trigger, .done_irq);
   timer_engine_model partner_u (.ref_clk, .resetn, .tpwm, .run, .slow, .dma_trigger,
      .timer_status, .xfer_done);

   task automatic tally(input logic ok, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (!ok) begin
         errors++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : tally

   task automatic cmp_bus(input logic [32:0] e, input logic [32:0] g);
      tally(g === e, 64'(e), 64'(g));
   endtask : cmp_bus

   task automatic cmp_tgt(input target_sel_t e, input target_sel_t g);
      tally(g === e, 64'(e), 64'(g));
   endtask : cmp_tgt

   task automatic cmp_pair(input logic [1:0] e, input logic [1:0] g);
      tally(g === e, 64'(e), 64'(g));
   endtask : cmp_pair

   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // one transfer; ex holds the expected error flag and read data; bb keeps psel for the next
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [32:0] ex, input logic bb);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      expq.push_back({wr, ex});
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      if (!bb) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end
   endtask : apb

   function automatic target_sel_t exp_tgt(input int c, input logic [3:0] k,
         input logic dst, input logic tp);
      target_sel_t t;
      t.valid = dst;
      t.addr = (c == 1 ? 32'hFFFF_FBC0 : 32'hFFFF_FB40) + {27'h0, k, 1'b0};
      t.id = target_id_t'(k);
      if (k == 4'h6 && !tp)
         t.id = TGT_PATTERN1;
      if (k == 4'h7 && !tp)
         t.id = TGT_PATTERN0;
      return t;
   endfunction : exp_tgt

   // bus answers at the access edge against the oldest note
   always @(posedge ref_clk) begin
      if (resetn && psel && penable)
         cmp_pair(2'b01, {1'b0, pready});
      if (resetn && psel && penable && pready) begin
         if (expq.size() == 0)
            tally(1'b0, 64'h0, 64'(prdata));
         else begin
            note = expq.pop_front();
            cmp_bus(note[32:0], {pslverr, note[33] ? 32'h0 : prdata});
         end
      end
   end

   // trigger and completion follow their own cause one cycle later
   always @(posedge ref_clk) begin
      if (resetn) begin
         cmp_pair(trig_exp, dma_trigger);
         cmp_pair(done_exp, done_irq);
      end
      trig_exp <= chan_enable & {timer_status[1].compare_match_irq
         | timer_status[1].overflow_irq, timer_status[0].compare_match_irq
         | timer_status[0].overflow_irq};
      done_exp <= xfer_done;
   end

   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      logic [31:0] w;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      dst_is_timer = 2'b11;
      chan_enable = 2'b00;
      tpwm = 2'b00;
      run = 2'b00;
      slow = 1'b0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, ch2_a, 32'h0, 4'hF, 33'h0, 1'b1);
      apb(1'b0, ch3_a, 32'h0, 4'hF, 33'h0, 1'b0);
      $display("reset test done");
      // codes 0 to 11 on both channels, random upper nibble, mode and destination
      for (int k = 0; k < 12; k++) begin
         for (int c = 0; c < 2; c++) begin
            w = $random(seed);
            tpwm[c] <= w[31];
            dst_is_timer[c] <= w[30];
            w[3:0] = 4'(k);
            apb(1'b1, c ? ch3_a : ch2_a, w, 4'hF, 33'h0, 1'b1);
            apb(1'b0, c ? ch3_a : ch2_a, 32'h0, 4'hF, 33'(k), 1'b0);
            repeat (3) @(posedge ref_clk);
            cmp_tgt(exp_tgt(c, 4'(k), w[30], w[31]), start_target[c]);
         end
      end
      $display("code test done");
      // single-bit access: set, ignored position, pointer only, other channel
      tpwm <= 2'b00;
      dst_is_timer <= 2'b11;
      apb(1'b1, ch2_a, 32'h0000_00F3, 4'hF, 33'h0, 1'b1);
      apb(1'b1, bit_a, 32'h0000_0302, 4'h3, 33'h0, 1'b1);
      apb(1'b1, bit_a, 32'h0000_0305, 4'h3, 33'h0, 1'b1);
      apb(1'b0, bit_a, 32'h0, 4'hF, 33'h0_0000_0005, 1'b1);
      apb(1'b1, bit_a, 32'h0000_0001, 4'h3, 33'h0, 1'b1);
      apb(1'b0, bit_a, 32'h0, 4'hF, 33'h0_0000_0101, 1'b1);
      apb(1'b1, bit_a, 32'h0000_1200, 4'h3, 33'h0, 1'b1);
      apb(1'b1, bit_a, 32'h0000_1306, 4'h3, 33'h0, 1'b1);
      apb(1'b0, ch2_a, 32'h0, 4'hF, 33'h0_0000_0007, 1'b1);
      apb(1'b0, ch3_a, 32'h0, 4'hF, 33'h0_0000_000A, 1'b0);
      repeat (3) @(posedge ref_clk);
      cmp_tgt(exp_tgt(0, 4'h7, 1'b1, 1'b0), start_target[0]);
      $display("bit test done");
      // unmapped places and a write without the low lane change nothing
      apb(1'b1, 12'h094, 32'h0000_0001, 4'hF, {1'b1, 32'h0}, 1'b1);
      apb(1'b1, ch2_a, 32'h0000_0002, 4'hE, 33'h0, 1'b1);
      apb(1'b0, 12'h0A4, 32'h0, 4'hF, {1'b1, 32'h0}, 1'b1);
      apb(1'b0, ch2_a, 32'h0, 4'hF, 33'h0_0000_0007, 1'b0);
      $display("refusal test done");
      // timer events trigger only enabled channels, prompt then slow engine
      chan_enable <= 2'b01;
      run <= 2'b11;
      repeat (40) @(posedge ref_clk);
      chan_enable <= 2'b10;
      slow <= 1'b1;
      repeat (40) @(posedge ref_clk);
      run <= 2'b00;
      chan_enable <= 2'b00;
      repeat (8) @(posedge ref_clk);
      $display("trigger test done");
      test_done();
   end
endmodule : testbench
